// ### hw/fscr_regs.sv
// Status two and non-volatile configuration one registers behind the serial link
// Operation
// [RULE1] Status two read by opcodes 07h and 65h
// [RULE2] Status two is read-only, writes ignored
// [RULE3] Status two resets zero, bits 7:3 zero
// [RULE4] Bit 2 holds last erase query result
// [RULE5] Host queries erase status before reading
// [RULE6] Host ignores erase result while suspended
// [RULE7] Bit 1 shows erase suspend mode
// [RULE8] Bit 0 shows program suspend mode
// [RULE9] Config written by 16-bit write-regs or write-any
// [RULE10] Opcodes 01h, 71h write; 65h reads config
// [RULE11] Bit 5 picks bottom-start protection, default 0
// [RULE12] Bit 2 puts parameter sectors on top
// [RULE13] Bit 1 gives quad enable reset value
// [RULE14] Bit 0 read-only zero, seeds protect lock
// [RULE15] Volatile select: write-regs sets volatile bits, reset 111
// [RULE16] Programmed one-time bits ignore writes of zero
// [RULE17] Config bits 7, 6, 4 stay zero
// [RULE18] Bit 3 defaults zero, one-time programmable only
`timescale 1ns/1ps
module fscr_regs
   import fscr_pkg::*;
#(
   parameter int ADDR_BITS = 24
) (
   // Core clock and resets
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic por_i,
   // Serial link
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_n_o,
   // Status from the embedded operation engine
   input wire logic erase_query_done_i,
   input wire logic erase_result_i,
   input wire logic erase_suspended_i,
   input wire logic program_suspended_i,
   // Configuration toward the array logic
   output logic [2:0] block_protect_o,
   output logic protect_from_bottom_o,
   output logic volatile_protect_sel_o,
   output logic param_sectors_top_o,
   output logic four_lane_en_o,
   output logic protect_lock_o
);

   // Merge a host write into the configuration register
   function automatic logic [7:0] cfg_merge(input logic [7:0] old_v, input logic [7:0] new_v);
      logic [7:0] res;
      res = (old_v | new_v) & CFG_OTP_MASK; // [RULE16] [RULE18]
      res = res | (new_v & CFG_WRITABLE_MASK); // [RULE13]
      return res; // [RULE14] [RULE17]
   endfunction : cfg_merge

   // Pick the byte returned for a read-any address
   function automatic logic [7:0] reg_pick(input logic [ADDR_BITS-1:0] a,
                                           input logic [7:0] st, input logic [7:0] cf);
      logic [7:0] res;
      res = 8'h00;
      if (a == ADDR_BITS'(ADDR_STATUS_TWO)) begin
         res = st; // [RULE1]
      end else if (a == ADDR_BITS'(ADDR_CONFIG_ONE)) begin
         res = cf; // [RULE10]
      end
      return res;
   endfunction : reg_pick

   // ---------------- Core clock domain ----------------
   logic [7:0] status_r, status_nxt; // Status two register
   logic [7:0] cfg_r, cfg_nxt; // Non-volatile configuration register
   logic [2:0] bp_vol_r, bp_vol_nxt; // Volatile block protect bits
   logic [2:0] bp_nv_r, bp_nv_nxt; // Non-volatile block protect bits
   logic quad_r, quad_nxt; // Volatile quad enable
   logic lock_r, lock_nxt; // Volatile protection lock
   logic tog_seen_r, tog_seen_nxt; // Last write toggle taken
   logic tog_sync; // Write toggle after two flops
   logic wr_ev; // One-cycle write event

   // ---------------- Link clock domain ----------------
   fscr_lst_type lst_r, lst_nxt; // Frame state
   logic [5:0] cnt_r, cnt_nxt; // Bit counter within a phase
   logic [31:0] sh_r, sh_nxt; // Input shift register
   logic [7:0] opc_r, opc_nxt; // Opcode of this frame
   logic [ADDR_BITS-1:0] addr_r, addr_nxt; // Address of this frame
   logic [7:0] obyte_r, obyte_nxt; // Byte being shifted out
   logic [2:0] oidx_r, oidx_nxt; // Output bit index
   logic tog_r, tog_nxt; // Write toggle toward the core
   logic [7:0] wr_opc_r, wr_opc_nxt; // Held write opcode
   logic [ADDR_BITS-1:0] wr_addr_r, wr_addr_nxt; // Held write address
   logic [15:0] wr_data_r, wr_data_nxt; // Held write data
   logic [15:0] rd_sync; // Status and config seen by the link
   logic [31:0] word; // Shift register with the current bit
   logic so_r; // Serial output flop
   logic so_oe_n_r; // Serial output enable flop

   assign word = {sh_r[30:0], si_i};

   // Register values cross into the link domain as levels
   fscr_sync #(.WIDTH(16)) u_rd_sync (
      .clk_i(sck_i),
      .d_i({status_r, cfg_r}),
      .q_o(rd_sync)
   );

   // Write toggle crosses into the core domain
   fscr_sync #(.WIDTH(1)) u_tog_sync (
      .clk_i(mclk_i),
      .d_i(tog_r),
      .q_o(tog_sync)
   );

   assign wr_ev = tog_sync ^ tog_seen_r;

   // Link frame decoder next state
   always_comb begin
      lst_nxt = lst_r;
      cnt_nxt = cnt_r + 6'h01;
      sh_nxt = word;
      opc_nxt = opc_r;
      addr_nxt = addr_r;
      obyte_nxt = obyte_r;
      oidx_nxt = oidx_r + 3'h1;
      tog_nxt = tog_r;
      wr_opc_nxt = wr_opc_r;
      wr_addr_nxt = wr_addr_r;
      wr_data_nxt = wr_data_r;
      case (lst_r)
         LST_OPC: begin
            // Opcode byte complete
            if (cnt_r == 6'(OPC_BITS - 1)) begin
               opc_nxt = word[7:0];
               cnt_nxt = 6'h00;
               oidx_nxt = 3'h0;
               if (word[7:0] == OPC_READ_STATUS_TWO) begin
                  lst_nxt = LST_OUT; // [RULE1]
                  obyte_nxt = rd_sync[15:8];
               end else if (word[7:0] == OPC_READ_ANY || word[7:0] == OPC_WRITE_ANY) begin
                  lst_nxt = LST_ADDR; // [RULE10]
               end else if (word[7:0] == OPC_WRITE_REGS) begin
                  lst_nxt = LST_IN; // [RULE10]
               end else begin
                  lst_nxt = LST_SKIP; // Other commands belong elsewhere
               end
            end
         end
         LST_ADDR: begin
            // Address complete
            if (cnt_r == 6'(ADDR_BITS - 1)) begin
               cnt_nxt = 6'h00;
               oidx_nxt = 3'h0;
               addr_nxt = word[ADDR_BITS-1:0];
               if (opc_r == OPC_READ_ANY) begin
                  lst_nxt = LST_OUT; // [RULE1] [RULE10]
                  obyte_nxt = reg_pick(word[ADDR_BITS-1:0], rd_sync[15:8], rd_sync[7:0]);
               end else begin
                  lst_nxt = LST_IN;
               end
            end
         end
         LST_IN: begin
            // Data complete: hold it and toggle toward the core
            if ((opc_r == OPC_WRITE_REGS && cnt_r == 6'(WRITE_REGS_BITS - 1)) ||
                (opc_r == OPC_WRITE_ANY && cnt_r == 6'(WRITE_ANY_BITS - 1))) begin
               lst_nxt = LST_SKIP; // [RULE9]
               tog_nxt = ~tog_r;
               wr_opc_nxt = opc_r;
               wr_addr_nxt = addr_r;
               wr_data_nxt = word[15:0];
            end
         end
         LST_OUT: begin
            // Reload after each byte so repeated reads track live state
            if (oidx_r == 3'h7) begin
               if (opc_r == OPC_READ_STATUS_TWO) begin
                  obyte_nxt = rd_sync[15:8];
               end else begin
                  obyte_nxt = reg_pick(addr_r, rd_sync[15:8], rd_sync[7:0]);
               end
            end
         end
         default: begin
            lst_nxt = LST_SKIP; // Wait for chip select to end the frame
         end
      endcase
   end

   // Frame state, cleared whenever chip select is high
   always_ff @(posedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         lst_r <= LST_OPC;
         cnt_r <= 6'h00;
         sh_r <= 32'h0000_0000;
         opc_r <= 8'h00;
         addr_r <= '0;
         obyte_r <= 8'h00;
         oidx_r <= 3'h0;
      end else begin
         lst_r <= lst_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         opc_r <= opc_nxt;
         addr_r <= addr_nxt;
         obyte_r <= obyte_nxt;
         oidx_r <= oidx_nxt;
      end
   end

   // Write hand-over registers survive frame ends
   always_ff @(posedge sck_i or posedge rst_i) begin
      if (rst_i) begin
         tog_r <= 1'b0;
         wr_opc_r <= 8'h00;
         wr_addr_r <= '0;
         wr_data_r <= 16'h0000;
      end else begin
         tog_r <= tog_nxt;
         wr_opc_r <= wr_opc_nxt;
         wr_addr_r <= wr_addr_nxt;
         wr_data_r <= wr_data_nxt;
      end
   end

   // Output bit changes on the falling edge, most significant first
   always_ff @(negedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         so_r <= 1'b0;
         so_oe_n_r <= 1'b1;
      end else begin
         so_r <= obyte_r[3'h7 - oidx_r];
         so_oe_n_r <= (lst_r != LST_OUT);
      end
   end

   assign so_o = so_r;
   assign so_oe_n_o = so_oe_n_r;

   // Core register next values
   always_comb begin
      status_nxt = STATUS_RESET; // [RULE2] [RULE3]
      status_nxt[ERASE_RESULT_BIT] = status_r[ERASE_RESULT_BIT];
      if (erase_query_done_i) begin
         status_nxt[ERASE_RESULT_BIT] = erase_result_i; // [RULE4]
      end
      status_nxt[ERASE_SUSP_BIT] = erase_suspended_i; // [RULE7]
      status_nxt[PROG_SUSP_BIT] = program_suspended_i; // [RULE8]
      cfg_nxt = cfg_r;
      bp_vol_nxt = bp_vol_r;
      bp_nv_nxt = bp_nv_r;
      quad_nxt = quad_r;
      lock_nxt = lock_r;
      tog_seen_nxt = tog_sync;
      if (wr_ev && wr_opc_r == OPC_WRITE_REGS) begin
         cfg_nxt = cfg_merge(cfg_r, wr_data_r[7:0]); // [RULE9] [RULE10]
         if (cfg_r[VOL_PROT_BIT]) begin
            bp_vol_nxt = wr_data_r[8+BP_MSB:8+BP_LSB]; // [RULE15]
         end else begin
            bp_nv_nxt = wr_data_r[8+BP_MSB:8+BP_LSB];
            bp_vol_nxt = wr_data_r[8+BP_MSB:8+BP_LSB];
         end
      end else if (wr_ev && wr_addr_r == ADDR_BITS'(ADDR_CONFIG_ONE)) begin
         cfg_nxt = cfg_merge(cfg_r, wr_data_r[7:0]); // [RULE9] [RULE10]
      end
   end

   // Core registers; reset reloads volatile copies from stored defaults
   always_ff @(posedge mclk_i) begin
      if (por_i) begin
         status_r <= STATUS_RESET;
         cfg_r <= CONFIG_RESET; // [RULE11] [RULE12] [RULE18]
         bp_nv_r <= BP_NV_RESET;
         bp_vol_r <= BP_NV_RESET;
         quad_r <= 1'b0;
         lock_r <= 1'b0;
         tog_seen_r <= tog_sync;
      end else if (rst_i) begin
         status_r <= STATUS_RESET; // [RULE3]
         bp_vol_r <= cfg_r[VOL_PROT_BIT] ? BP_VOL_RESET : bp_nv_r; // [RULE15]
         quad_r <= cfg_r[FOUR_LANE_BIT]; // [RULE13]
         lock_r <= cfg_r[FREEZE_DEF_BIT]; // [RULE14]
         tog_seen_r <= tog_sync;
      end else begin
         status_r <= status_nxt;
         cfg_r <= cfg_nxt;
         bp_vol_r <= bp_vol_nxt;
         bp_nv_r <= bp_nv_nxt;
         quad_r <= quad_nxt;
         lock_r <= lock_nxt;
         tog_seen_r <= tog_seen_nxt;
      end
   end

   assign block_protect_o = bp_vol_r;
   assign protect_from_bottom_o = cfg_r[PROT_BOTTOM_BIT]; // [RULE11]
   assign volatile_protect_sel_o = cfg_r[VOL_PROT_BIT];
   assign param_sectors_top_o = cfg_r[PARAM_TOP_BIT]; // [RULE12]
   assign four_lane_en_o = quad_r;
   assign protect_lock_o = lock_r;

   // Checks on the core domain
   status_rsvd_a: assert property (@(posedge mclk_i) disable iff (rst_i || por_i) // [RULE3]
      status_r[7:3] == 5'h00) else $error("status two reserved bits not zero");
   erase_capture_a: assert property (@(posedge mclk_i) disable iff (rst_i || por_i) // [RULE4]
      erase_query_done_i ##1 !rst_i && !por_i
      |-> status_r[ERASE_RESULT_BIT] == $past(erase_result_i))
      else $error("erase result not captured");
   erase_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i || por_i) // [RULE2]
      !erase_query_done_i |=> $stable(status_r[ERASE_RESULT_BIT]) || $past(rst_i) || $past(por_i))
      else $error("erase result changed without a query");
   erase_susp_a: assert property (@(posedge mclk_i) disable iff (rst_i || por_i) // [RULE7]
      $rose(erase_suspended_i) |=> status_r[ERASE_SUSP_BIT] ##1 1'b1)
      else $error("erase suspend flag late");
   prog_susp_a: assert property (@(posedge mclk_i) disable iff (rst_i || por_i) // [RULE8]
      !program_suspended_i |=> !status_r[PROG_SUSP_BIT])
      else $error("program suspend flag stuck");
   otp_sticky_a: assert property (@(posedge mclk_i) disable iff (por_i) // [RULE16]
      (cfg_r & CFG_OTP_MASK) != 8'h00 |=> ((cfg_r & $past(cfg_r) & CFG_OTP_MASK)
      == ($past(cfg_r) & CFG_OTP_MASK))) else $error("one-time bit lost");
   cfg_rsvd_a: assert property (@(posedge mclk_i) disable iff (por_i) // [RULE17]
      cfg_r[7:6] == 2'b00 && !cfg_r[4] && !cfg_r[FREEZE_DEF_BIT])
      else $error("config reserved or read-only bit set");
   bp_reset_a: assert property (@(posedge mclk_i) disable iff (por_i) // [RULE15]
      rst_i && cfg_r[VOL_PROT_BIT] |=> bp_vol_r == BP_VOL_RESET)
      else $error("volatile protect bits not 111 after reset");
   quad_load_a: assert property (@(posedge mclk_i) disable iff (por_i) // [RULE13]
      rst_i |=> quad_r == $past(cfg_r[FOUR_LANE_BIT]))
      else $error("quad enable not loaded from default");
   cfg_write_a: assert property (@(posedge mclk_i) disable iff (rst_i || por_i) // [RULE10]
      wr_ev && (wr_opc_r == OPC_WRITE_REGS || wr_addr_r == ADDR_BITS'(ADDR_CONFIG_ONE))
      |=> cfg_r[FOUR_LANE_BIT] == $past(wr_data_r[FOUR_LANE_BIT]))
      else $error("config write not applied");

   // Checks on the link domain
   read_two_a: assert property (@(posedge sck_i) disable iff (cs_n_i) // [RULE1]
      lst_r == LST_OPC && cnt_r == 6'(OPC_BITS - 1) && word[7:0] == OPC_READ_STATUS_TWO
      |=> lst_r == LST_OUT && obyte_r == $past(rd_sync[15:8]))
      else $error("status two read not started");

endmodule : fscr_regs

// ### hw/fscr_pkg.sv
// Shared constants and types for the flash status and configuration register block
package fscr_pkg;

   // Command opcodes seen on the serial link
   localparam logic [7:0] OPC_READ_STATUS_TWO = 8'h07;
   localparam logic [7:0] OPC_READ_ANY = 8'h65;
   localparam logic [7:0] OPC_WRITE_REGS = 8'h01;
   localparam logic [7:0] OPC_WRITE_ANY = 8'h71;

   // Register addresses used by the any-register commands
   localparam logic [23:0] ADDR_STATUS_TWO = 24'h000002;
   localparam logic [23:0] ADDR_CONFIG_ONE = 24'h000003;

   // Bit positions in the status two register
   localparam int ERASE_RESULT_BIT = 2;
   localparam int ERASE_SUSP_BIT = 1;
   localparam int PROG_SUSP_BIT = 0;

   // Bit positions in the non-volatile configuration register
   localparam int PROT_BOTTOM_BIT = 5;
   localparam int VOL_PROT_BIT = 3;
   localparam int PARAM_TOP_BIT = 2;
   localparam int FOUR_LANE_BIT = 1;
   localparam int FREEZE_DEF_BIT = 0;

   // Block protect field inside the first write-registers data byte
   localparam int BP_LSB = 2;
   localparam int BP_MSB = 4;

   // Field masks of the configuration register
   localparam logic [7:0] CFG_OTP_MASK = 8'h2C;
   localparam logic [7:0] CFG_WRITABLE_MASK = 8'h02;

   // Reset values
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [2:0] BP_VOL_RESET = 3'h7;
   localparam logic [2:0] BP_NV_RESET = 3'h0;

   // Frame lengths in link clock bits
   localparam int OPC_BITS = 8;
   localparam int WRITE_REGS_BITS = 16;
   localparam int WRITE_ANY_BITS = 8;

   // Link frame states, one-hot
   typedef enum logic [4:0] {
      LST_OPC = 5'b00001,
      LST_ADDR = 5'b00010,
      LST_IN = 5'b00100,
      LST_OUT = 5'b01000,
      LST_SKIP = 5'b10000
   } fscr_lst_type;

endpackage : fscr_pkg

// ### hw/fscr_sync.sv
// Two-flop synchroniser for quasi-static levels entering a clock domain
`timescale 1ns/1ps
module fscr_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock
   input wire logic clk_i,
   // Level from the other domain
   input wire logic [WIDTH-1:0] d_i,
   // Synchronised level
   output logic [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta_r; // First stage, read only by the second
   logic [WIDTH-1:0] q_r; // Second stage

   // Two stages, no logic between them
   always_ff @(posedge clk_i) begin
      meta_r <= d_i;
      q_r <= meta_r;
   end

   assign q_o = q_r;

endmodule : fscr_sync

// ### tb/fscr_host.sv
// Serial host controller model that frames register commands on the link
`timescale 1ns/1ps
module fscr_host (
   // Link toward the device
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o,
   // Read data back from the device
   input wire logic so_i,
   input wire logic so_oe_n_i
);
   localparam time HALF = 80ns; // Half of the 160 ns link period

   // Idle link: clock parked low, select high; its late rise clears the frame logic
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b0;
      si_o = 1'b0;
      #1 cs_n_o = 1'b1;
   end

   // Shift one bit out, data set up half a period before the rising edge
   task automatic put_bit(input logic b);
      si_o = b;
      #HALF sck_o = 1'b1;
      #HALF sck_o = 1'b0;
   endtask : put_bit

   // One whole frame: opcode, optional address, write bits, then an optional read byte
   task automatic frame(input logic [7:0] opc, input logic use_addr, input logic [23:0] addr,
                        input int nwr, input logic [15:0] wdat, input logic rd,
                        output logic [7:0] rdat);
      rdat = 8'h00;
      // Odd offset keeps link edges away from the core clock edges
      #3.7 cs_n_o = 1'b0;
      #HALF;
      for (int i = 7; i >= 0; i--) put_bit(opc[i]);
      if (use_addr) begin
         for (int i = 23; i >= 0; i--) put_bit(addr[i]);
      end
      // The low nwr bits of the write data go out, MSB first
      for (int i = nwr - 1; i >= 0; i--) put_bit(wdat[i]);
      if (rd) begin
         for (int i = 7; i >= 0; i--) begin
            // Data line toggles while unused, so no stale value is left on it
            si_o = ~si_o;
            #HALF sck_o = 1'b1;
            // A bit seen while the output is not enabled is unusable
            rdat[i] = so_oe_n_i ? 1'bx : so_i;
            #HALF sck_o = 1'b0;
         end
      end
      // Released data line shows the inverse of the last bit
      si_o = ~si_o;
      #HALF cs_n_o = 1'b1;
      #HALF;
   endtask : frame
endmodule : fscr_host

// ### tb/fscr_regs_tb.sv
// Self-checking bench for the status two and configuration one register block
`timescale 1ns/1ps
module fscr_regs_tb;
   import fscr_pkg::*;
   // Core clock, resets and engine status
   logic mclk_i = 1'b0;
   logic rst_i = 1'b0;
   logic por_i = 1'b1;
   logic erase_query_done_i = 1'b0;
   logic erase_result_i = 1'b0;
   logic erase_suspended_i = 1'b0;
   logic program_suspended_i = 1'b0;
   // Link wires between host model and device
   logic sck_i, cs_n_i, si_i, so_o, so_oe_n_o;
   // Configuration outputs
   logic [2:0] block_protect_o;
   logic protect_from_bottom_o, volatile_protect_sel_o, param_sectors_top_o;
   logic four_lane_en_o, protect_lock_o;
   // Counters and read-back holder
   int failures = 0;
   int checked = 0;
   logic [7:0] rd;

   fscr_regs #(.ADDR_BITS(24)) fscr_regs_inst (
      .mclk_i(mclk_i), .rst_i(rst_i), .por_i(por_i),
      .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
      .erase_query_done_i(erase_query_done_i), .erase_result_i(erase_result_i),
      .erase_suspended_i(erase_suspended_i), .program_suspended_i(program_suspended_i),
      .block_protect_o(block_protect_o), .protect_from_bottom_o(protect_from_bottom_o),
      .volatile_protect_sel_o(volatile_protect_sel_o),
      .param_sectors_top_o(param_sectors_top_o),
      .four_lane_en_o(four_lane_en_o), .protect_lock_o(protect_lock_o));

   fscr_host fscr_host_inst (
      .sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o), .so_oe_n_i(so_oe_n_o));

   // Core clock, 10 ns period
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   // Compare one byte and count it
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Print counts and the verdict, then stop
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop

   // Packed outputs: bottom, volatile sel, top params, quad, lock, protect bits
   function automatic logic [7:0] outs();
      return {protect_from_bottom_o, volatile_protect_sel_o, param_sectors_top_o,
              four_lane_en_o, protect_lock_o, block_protect_o};
   endfunction : outs

   // Wait on falling core clock edges
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : cyc

   // Command wrappers; each leaves time for the write to commit
   task automatic rd_stat(output logic [7:0] v);
      fscr_host_inst.frame(OPC_READ_STATUS_TWO, 1'b0, 24'h0, 0, 16'h0, 1'b1, v);
      cyc(8);
   endtask : rd_stat

   task automatic rd_any(input logic [23:0] a, output logic [7:0] v);
      fscr_host_inst.frame(OPC_READ_ANY, 1'b1, a, 0, 16'h0, 1'b1, v);
      cyc(8);
   endtask : rd_any

   task automatic wr_any(input logic [23:0] a, input logic [7:0] d);
      logic [7:0] unused;
      fscr_host_inst.frame(OPC_WRITE_ANY, 1'b1, a, 8, {8'h00, d}, 1'b0, unused);
      cyc(8);
   endtask : wr_any

   task automatic wr_regs(input int n, input logic [15:0] d);
      logic [7:0] unused;
      fscr_host_inst.frame(OPC_WRITE_REGS, 1'b0, 24'h0, n, d, 1'b0, unused);
      cyc(8);
   endtask : wr_regs

   // Hardware reset in mid-run, link idle
   task automatic pulse_rst();
      rst_i = 1'b1;
      cyc(2);
      rst_i = 1'b0;
      cyc(2);
   endtask : pulse_rst

   // Reset values of both registers and of the outputs
   task automatic sc_defaults();
      rd_stat(rd);
      chk("status two at reset", STATUS_RESET, rd);
      rd_any(ADDR_CONFIG_ONE, rd);
      chk("config at reset", CONFIG_RESET, rd);
      chk("outputs at reset", 8'h00, outs());
      chk("output enable idle", 8'h01, {7'h00, so_oe_n_o});
   endtask : sc_defaults

   // Suspend flags, erase result capture and refused status writes
   task automatic sc_status();
      erase_suspended_i = 1'b1;
      cyc(4);
      rd_stat(rd);
      chk("erase suspend flag", 8'h02, rd);
      erase_suspended_i = 1'b0;
      program_suspended_i = 1'b1;
      cyc(4);
      rd_any(ADDR_STATUS_TWO, rd);
      chk("program suspend flag", 8'h01, rd);
      program_suspended_i = 1'b0;
      // Query finishes while nothing is suspended, right before the read
      erase_result_i = 1'b1;
      erase_query_done_i = 1'b1;
      cyc(1);
      erase_query_done_i = 1'b0;
      erase_result_i = 1'b0;
      cyc(4);
      rd_stat(rd);
      chk("erase result held", 8'h04, rd);
      wr_any(ADDR_STATUS_TWO, 8'hFF);
      rd_any(ADDR_STATUS_TWO, rd);
      chk("status two after write", 8'h04, rd);
      erase_query_done_i = 1'b1;
      cyc(1);
      erase_query_done_i = 1'b0;
      cyc(4);
      rd_stat(rd);
      chk("erase not completed", 8'h00, rd);
   endtask : sc_status

   // Write-registers with non-volatile protect bits selected
   task automatic sc_write_regs();
      wr_regs(8, 16'h001C);
      chk("short frame ignored", 8'h00, outs());
      wr_regs(16, 16'h1402);
      rd_any(ADDR_CONFIG_ONE, rd);
      chk("config by write regs", 8'h02, rd);
      chk("protect follows write", 8'h05, outs());
      pulse_rst();
      chk("quad loaded at reset", 8'h15, outs());
   endtask : sc_write_regs

   // One-time bits, reserved bits and volatile protect bits
   task automatic sc_otp();
      logic [7:0] unused;
      wr_any(ADDR_CONFIG_ONE, 8'hFF);
      rd_any(ADDR_CONFIG_ONE, rd);
      chk("config reserved zero", 8'h2E, rd);
      chk("one-time outputs", 8'hF5, outs());
      wr_any(ADDR_CONFIG_ONE, 8'h00);
      rd_any(ADDR_CONFIG_ONE, rd);
      chk("one-time bits kept", 8'h2C, rd);
      pulse_rst();
      chk("volatile protect reset", 8'hE7, outs());
      wr_regs(16, 16'h082C);
      chk("volatile protect write", 8'hE2, outs());
      rd_any(ADDR_CONFIG_ONE, rd);
      chk("config after write regs", 8'h2C, rd);
      pulse_rst();
      chk("volatile protect again", 8'hE7, outs());
      // Unmapped address reads zero; an undecoded opcode with a payload changes nothing
      rd_any(24'h000010, rd);
      chk("unmapped address", 8'h00, rd);
      fscr_host_inst.frame(8'h5A, 1'b0, 24'h0, 16, 16'h0002, 1'b0, unused);
      cyc(8);
      rd_any(ADDR_CONFIG_ONE, rd);
      chk("unknown opcode ignored", 8'h2C, rd);
      chk("outputs after unknown opcode", 8'hE7, outs());
   endtask : sc_otp

   // Main sequence
   initial begin
      // A real rising edge of reset clears the link hand-over flops
      #1 rst_i = 1'b1;
      cyc(16);
      rst_i = 1'b0;
      por_i = 1'b0;
      cyc(4);
      sc_defaults();
      sc_status();
      sc_write_regs();
      sc_otp();
      report_and_stop();
   end

   // Bound on the whole run
   initial begin
      repeat (100000) @(posedge mclk_i);
      failures++;
      report_and_stop();
   end
endmodule : fscr_regs_tb
